// file: hdl/sar_adc_defines.svh
// Constants shared by both ends of the converter serial link
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH
`define SAR_CLK_NS          50
`define SAR_T_CONV_MIN_NS   500
`define SAR_T_CONV_MAX_NS   2200
`define SAR_CONV_MIN_CYC    ((`SAR_T_CONV_MIN_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_CONV_MAX_CYC    (`SAR_T_CONV_MAX_NS / `SAR_CLK_NS)
`define SAR_CONV_DONE       6'(`SAR_CONV_MAX_CYC - 1)
`define SAR_BITS_PLAIN      5'h10
`define SAR_BITS_BUSY       5'h11
`define SAR_CODE_MAX        16'hffff
`define SAR_CODE_MIN        16'h0000
`define SAR_HOST_HOLD       6'h04
`define SAR_HOST_MARGIN     6'h06
`define SAR_HOST_WAIT       6'(`SAR_CONV_MAX_CYC + 6)
`define SAR_HOST_HALF       6'h08
`define SAR_HOST_PERIOD     6'h10
`define SAR_REG_CTRL        8'h00
`define SAR_REG_STATUS      8'h04
`define SAR_REG_DATA        8'h08
`define SAR_CTRL_START      0
`define SAR_CTRL_FOUR_WIRE  1
`define SAR_CTRL_USE_BUSY   2
`define SAR_STAT_ACTIVE     0
`define SAR_STAT_DONE       1
`endif

// file: hdl/sar_adc_pkg.sv
// Types shared by both ends of the converter serial link
package sar_adc_pkg;
    // Converter sequencing states
    typedef enum logic [3:0] {
        ST_ACQ   = 4'b0001,
        ST_CONV  = 4'b0010,
        ST_READY = 4'b0100,
        ST_SHIFT = 4'b1000
    } dev_state_t;
    // Controller sequencing states
    typedef enum logic [4:0] {
        HS_IDLE = 5'b00001,
        HS_CNV  = 5'b00010,
        HS_WAIT = 5'b00100,
        HS_SEL  = 5'b01000,
        HS_CLK  = 5'b10000
    } host_state_t;
endpackage : sar_adc_pkg

// file: hdl/sar_link_if.sv
// Serial link between converter and controller
`timescale 1ns/1ps
interface sar_link_if;
    logic convert_start;    // Conversion start / select, from controller
    logic serial_clock;     // Readout clock, from controller
    logic serial_data_in;   // Mode / select line, from controller
    logic sdo_out;          // Converter data bit
    logic sdo_oe_n;         // Converter drive enable, low drives
    logic sdo_line;         // Resolved line level
    // External pull-up: an undriven line reads high
    assign sdo_line = sdo_oe_n ? 1'b1 : sdo_out;
    modport device (input convert_start, input serial_clock, input serial_data_in,
                    output sdo_out, output sdo_oe_n);
    modport host (output convert_start, output serial_clock, output serial_data_in,
                  input sdo_line);
endinterface : sar_link_if

// file: hdl/sar_adc_device.sv
// Converter end: mode selection, conversion timing and serial readout
// Behaviour
// - Sample data-in level at start rise: mode
// - Data-in tied to start selects chain
// - Power down after each conversion
// - Select mode busy if line low at end
// - Chain busy if clock high at start
// - Start rise begins conversion, output floats
// - Conversion runs to end; busy floats meanwhile
// - Host waits max time without busy
// - 3-wire: start fall gives MSB, shift on falls
// - Output changes on clock falling edges
// - 3-wire: float after 16th fall or start rise
// - 3-wire no busy: host restores start early
// - Select busy: output driven low at completion
// - Busy: start bit first; select mode floats after 17th fall
// - 3-wire busy: host lowers start early
// - 4-wire: host keeps start high throughout
// - Both lines low: output driven low
// - 4-wire no busy: host restores data-in early
// - 4-wire: data-in fall gives MSB, float later
// - 4-wire busy: host lowers data-in early
// - Contention on output is harmless
// - Straight binary, saturating code
// - Internal clock times the conversion
`timescale 1ns/1ps
`include "sar_adc_defines.svh"
module sar_adc_device (
    input  wire logic               clk,
    input  wire logic               rst_n,
    sar_link_if.device              link,
    input  wire logic signed [17:0] analog_code,
    output logic             [15:0] last_result,
    output logic                    converting,
    output logic                    powered_down,
    output logic                    chain_mode,
    output logic                    busy_enabled
);
    import sar_adc_pkg::*;

    // Clamp the sampled input into the unsigned code range
    function automatic logic [15:0] saturate(input logic signed [17:0] v);
        if (v < 0)
            return `SAR_CODE_MIN;
        else if (v > 18'sd65535)
            return `SAR_CODE_MAX;
        else
            return v[15:0];
    endfunction : saturate

    dev_state_t  state;         // Sequencing state
    dev_state_t  next_state;    // Next sequencing state
    logic [2:0]  pin_meta;      // First sync stage {start, data-in, clock}
    logic [2:0]  pin_sync;      // Second sync stage
    logic [2:0]  pin_prev;      // Previous synced sample, for edges
    logic [5:0]  conv_cnt;      // Internal conversion timer
    logic [15:0] result;        // Held conversion result
    logic [16:0] shift_reg;     // Output shifter, bit 16 on the pin
    logic [4:0]  bit_cnt;       // Falling edges seen in readout
    logic        busy_mode;     // Start bit in front of data
    logic        mode_chain;    // Chain mode selected

    // Decoded pin levels and edges
    wire cnv_s      = pin_sync[2];
    wire sdi_s      = pin_sync[1];
    wire cnv_rise   = pin_sync[2] & ~pin_prev[2];
    wire cnv_fall   = ~pin_sync[2] & pin_prev[2];
    wire sck_fall   = ~pin_sync[0] & pin_prev[0];
    wire sel_act    = ~(pin_sync[2] & pin_sync[1]);
    wire sel_prev   = ~(pin_prev[2] & pin_prev[1]);
    wire sel_fall   = sel_act & ~sel_prev;
    wire sel_rise   = ~sel_act & sel_prev;
    wire both_low   = ~cnv_s & ~sdi_s;
    wire conv_done  = (state == ST_CONV) && (conv_cnt == `SAR_CONV_DONE);
    // In select mode busy is decided by the select lines at completion
    wire busy_now   = mode_chain ? busy_mode : sel_act;
    wire [4:0] bit_limit = busy_mode ? `SAR_BITS_BUSY : `SAR_BITS_PLAIN;
    wire shift_live = (state == ST_SHIFT) &&
                      (mode_chain || (sel_act && (bit_cnt < bit_limit)));
    wire next_oe_n  = ~(both_low | shift_live);
    wire next_bit   = both_low ? 1'b0 : shift_reg[16];

    // Two-stage sync of the link pins; only pin_sync reads pin_meta
    // Edges show two to three clocks after the pin moves; the host allows for it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
            pin_prev <= 3'h0;
        end else begin
            pin_meta <= {link.convert_start, link.serial_data_in, link.serial_clock};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            ST_ACQ: begin
                if (cnv_rise)
                    next_state = ST_CONV;
            end
            ST_CONV: begin
                // Further start edges are ignored until done
                if (conv_done)
                    next_state = (mode_chain || busy_now) ? ST_SHIFT : ST_READY;
            end
            ST_READY: begin
                if (cnv_rise)
                    next_state = ST_CONV;
                else if (sel_fall)
                    next_state = ST_SHIFT;
            end
            ST_SHIFT: begin
                // A new start edge outranks any deselect in the same cycle
                if (cnv_rise)
                    next_state = ST_CONV;
                else if (mode_chain ? cnv_fall : sel_rise)
                    next_state = ST_ACQ;
            end
            default: next_state = ST_ACQ;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            state <= ST_ACQ;
        else
            state <= next_state;
    end

    // Mode and busy capture at the start edge; select-mode busy is taken again at completion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_chain <= 1'b0;
            busy_mode  <= 1'b0;
        end else if (cnv_rise && state != ST_CONV) begin
            // Level just before the edge: a tied line reads low
            mode_chain <= ~pin_prev[1];
            busy_mode  <= ~pin_prev[1] & pin_prev[0];
        end else if (conv_done && !mode_chain) begin
            busy_mode  <= sel_act;
        end
    end

    // Conversion timer on the internal clock; sample held at the start
    // Completion always lands on the maximum time, safe for any host timing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_cnt <= 6'h00;
            result   <= `SAR_CODE_MIN;
        end else if (cnv_rise && state != ST_CONV) begin
            conv_cnt <= 6'h00;
            result   <= saturate(analog_code);
        end else if (state == ST_CONV) begin
            conv_cnt <= conv_cnt + 6'h01;
        end
    end

    // Output shifter: loaded at completion, advanced on clock falls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 17'h00000;
            bit_cnt   <= 5'h00;
        end else if (conv_done) begin
            // Busy puts a start bit ahead of the MSB: low in select mode
            shift_reg <= busy_now ? {mode_chain, result} : {result, 1'b0};
            bit_cnt   <= 5'h00;
        end else if (state == ST_READY && sel_fall) begin
            bit_cnt   <= 5'h00;
        end else if (state == ST_SHIFT && sck_fall && bit_cnt < bit_limit) begin
            shift_reg <= {shift_reg[15:0], mode_chain & sdi_s};
            bit_cnt   <= bit_cnt + 5'h01;
        end
    end

    // Pin drive; registered so the pin never glitches on decode.
    // Several converters may drive together; the pad tolerates it.
    // Both-low drive wins over the shifter in every state, conversion included
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link.sdo_out  <= 1'b0;
            link.sdo_oe_n <= 1'b1;
        end else begin
            link.sdo_out  <= next_bit;
            link.sdo_oe_n <= next_oe_n;
        end
    end

    // Status towards the user side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            last_result <= `SAR_CODE_MIN;
        else if (conv_done)
            last_result <= result;
    end

    // Power drops once the conversion phase ends
    assign converting   = (state == ST_CONV);
    assign powered_down = (state != ST_CONV);
    assign chain_mode   = mode_chain;
    assign busy_enabled = busy_mode;
endmodule : sar_adc_device

// file: hdl/sar_adc_host.sv
// Controller end: APB registers, conversion start and select-mode readout
`timescale 1ns/1ps
`include "sar_adc_defines.svh"
module sar_adc_host (
    input  wire logic        clk,
    input  wire logic        rst_n,
    sar_link_if.host         link,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    import sar_adc_pkg::*;

    host_state_t state;      // Sequencing state
    logic [5:0]  cnt;        // Phase timer
    logic [4:0]  nbits;      // Clock periods issued
    logic [16:0] rx;         // Bits sampled on rising edges
    logic [15:0] data;       // Last result
    logic        four_wire;  // Separate select line
    logic        use_busy;   // Wait for start bit
    logic        done;       // Sticky completion flag
    logic        sdo_meta;   // First sync stage
    logic        sdo_s;      // Synced line level

    // APB decode
    wire access    = psel & penable;
    wire wr        = access & pwrite;
    wire hit_ctrl  = (paddr == `SAR_REG_CTRL);
    wire hit_stat  = (paddr == `SAR_REG_STATUS);
    wire hit_data  = (paddr == `SAR_REG_DATA);
    wire mapped    = hit_ctrl | hit_stat | hit_data;
    // A start needs a fresh rising edge, so it is refused while start still stands high
    wire go        = wr & hit_ctrl & pwdata[`SAR_CTRL_START] & (state == HS_IDLE) &
                     ~link.convert_start;
    wire clr_done  = wr & hit_stat & pwdata[`SAR_STAT_DONE];
    wire [4:0] total = use_busy ? `SAR_BITS_BUSY : `SAR_BITS_PLAIN;
    wire finish    = (state == HS_CLK) && (cnt == `SAR_HOST_PERIOD - 6'h01) &&
                     (nbits == total);
    // Always ready; unmapped addresses get an error
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = hit_ctrl ? {29'h0, use_busy, four_wire, 1'b0} :
                     hit_stat ? {30'h0, done, state != HS_IDLE} :
                     hit_data ? {16'h0, data} : 32'h0;

    // Line sync
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sdo_meta <= 1'b1;
            sdo_s    <= 1'b1;
        end else begin
            sdo_meta <= link.sdo_line;
            sdo_s    <= sdo_meta;
        end
    end

    // Configuration and sticky done; a new completion beats a clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            four_wire <= 1'b0;
            use_busy  <= 1'b0;
            done      <= 1'b0;
        end else begin
            if (wr && hit_ctrl && state == HS_IDLE) begin
                four_wire <= pwdata[`SAR_CTRL_FOUR_WIRE];
                use_busy  <= pwdata[`SAR_CTRL_USE_BUSY];
            end
            if (finish)
                done <= 1'b1;
            else if (clr_done)
                done <= 1'b0;
        end
    end

    // Sequencer and pin drive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state               <= HS_IDLE;
            cnt                 <= 6'h00;
            nbits               <= 5'h00;
            rx                  <= 17'h00000;
            data                <= 16'h0000;
            link.convert_start  <= 1'b0;
            link.serial_clock   <= 1'b0;
            link.serial_data_in <= 1'b1;
        end else begin
            cnt <= cnt + 6'h01;
            unique case (state)
                HS_IDLE: begin
                    // Data-in high at the start edge picks select mode
                    if (go) begin
                        link.serial_data_in <= 1'b1;
                        link.convert_start  <= 1'b1;
                        cnt                 <= 6'h00;
                        state               <= HS_CNV;
                    end else begin
                        // 4-wire leaves start high after a read; drop it for the next rise
                        link.convert_start  <= 1'b0;
                    end
                end
                HS_CNV: begin
                    // Busy: drop the select line well before min time
                    if (cnt == `SAR_HOST_HOLD - 6'h01) begin
                        if (use_busy && four_wire)
                            link.serial_data_in <= 1'b0;
                        else if (use_busy)
                            link.convert_start  <= 1'b0;
                        cnt   <= 6'h00;
                        state <= HS_WAIT;
                    end
                end
                HS_WAIT: begin
                    // No busy: sit out the max time plus sync latency
                    if (use_busy ? !sdo_s : (cnt == `SAR_HOST_WAIT - 6'h01)) begin
                        if (!use_busy && four_wire)
                            link.serial_data_in <= 1'b0;
                        else if (!use_busy)
                            link.convert_start  <= 1'b0;
                        cnt   <= 6'h00;
                        nbits <= 5'h00;
                        state <= use_busy ? HS_CLK : HS_SEL;
                    end
                end
                HS_SEL: begin
                    if (cnt == `SAR_HOST_HALF - 6'h01) begin
                        cnt   <= 6'h00;
                        state <= HS_CLK;
                    end
                end
                HS_CLK: begin
                    // Sample on the rise, long after the device's update
                    if (cnt == 6'h00) begin
                        link.serial_clock <= 1'b1;
                        rx                <= {rx[15:0], sdo_s};
                    end else if (cnt == `SAR_HOST_HALF) begin
                        link.serial_clock <= 1'b0;
                        nbits             <= nbits + 5'h01;
                    end
                    if (cnt == `SAR_HOST_PERIOD - 6'h01) begin
                        cnt <= 6'h00;
                        if (nbits == total) begin
                            // Deselect raises data-in; in 3-wire start stays low, so select lasts to the next start
                            data                <= rx[15:0];
                            link.serial_data_in <= 1'b1;
                            state               <= HS_IDLE;
                        end
                    end
                end
                default: state <= HS_IDLE;
            endcase
        end
    end
endmodule : sar_adc_host

// file: verif/sar_link_assertions.sv
// Concurrent checks on the controller to converter serial link
`timescale 1ns/1ps
`include "sar_adc_defines.svh"
module sar_link_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic convert_start,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    input wire logic sdo_out,
    input wire logic sdo_oe_n,
    input wire logic sdo_line
);
    localparam int CONV_MIN = `SAR_CONV_MIN_CYC;
    localparam int CONV_MAX = `SAR_CONV_MAX_CYC;
    logic [7:0] since_rise;  // Cycles since start rose, saturating
    logic [4:0] falls;       // Clock falls since the pin was driven
    logic       busy_rd;     // Drive began at completion, start bit first
    logic       unread;      // Result not yet driven out
    logic       cs_q;        // Edge history
    logic       sck_q;
    logic       oe_q;
    wire        cs_rise = convert_start & ~cs_q;
    wire        sck_fall = ~serial_clock & sck_q;
    wire        drv_on = ~sdo_oe_n & oe_q;
    wire  [7:0] next_since = cs_rise ? 8'h00 : since_rise + {7'h00, since_rise != 8'hff};
    // History and counters; saturating so a long idle never wraps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_q <= 1'b0;
            sck_q <= 1'b0;
            oe_q <= 1'b1;
            since_rise <= 8'hff;
            falls <= 5'h00;
            busy_rd <= 1'b0;
            unread <= 1'b0;
        end else begin
            cs_q <= convert_start;
            sck_q <= serial_clock;
            oe_q <= sdo_oe_n;
            since_rise <= next_since;
            falls <= drv_on ? 5'h00 : falls + {4'h0, sck_fall && falls != 5'h1f};
            busy_rd <= drv_on ? (since_rise < 8'd50) : busy_rd;
            unread <= cs_rise | (unread & ~drv_on);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_START_FLOATS: assert property ($rose(convert_start) && serial_data_in
        |-> ##[1:6] sdo_oe_n)
        else $error("output not released after start rise");
    AST_CONV_FLOAT: assert property ($rose(convert_start) && serial_data_in
        |-> ##5 sdo_oe_n [*6])
        else $error("output driven early in conversion");
    AST_NO_EARLY_DRIVE: assert property ($fell(sdo_oe_n) |-> since_rise >= CONV_MIN)
        else $error("output driven before minimum conversion time");
    AST_BUSY_LOW: assert property ($rose(convert_start) && serial_data_in ##8
        (!convert_start || !serial_data_in) |-> ##[28:48] (!sdo_oe_n && !sdo_line))
        else $error("start bit not driven low at completion");
    AST_MSB_ON_SELECT: assert property (unread && since_rise >= CONV_MAX &&
        ($fell(convert_start) && serial_data_in || $fell(serial_data_in) && convert_start)
        |-> ##[1:6] !sdo_oe_n)
        else $error("select fall did not drive the first bit");
    AST_SELECT_RISE: assert property ($rose(serial_data_in) && convert_start
        |-> ##[1:6] sdo_oe_n)
        else $error("output not released on select rise");
    AST_HOLD_HIGH: assert property (serial_clock [*6] ##0 !sdo_oe_n |-> $stable(sdo_out))
        else $error("data changed while clock high");
    AST_COUNT_CAP: assert property (!sdo_oe_n |-> falls <= (busy_rd ? 5'd17 : 5'd16))
        else $error("output driven past the last bit");
    AST_LAST_FALL: assert property (sck_fall && !sdo_oe_n &&
        falls == (busy_rd ? 5'd16 : 5'd15) |-> ##[1:6] sdo_oe_n)
        else $error("output not released after last fall");
endmodule : sar_link_assertions

// file: verif/tb_top.sv
// Bench: controller reads one converter, the bench drives a second
`timescale 1ns/1ps
`include "sar_adc_defines.svh"
module tb_top;
    logic               clk;
    logic               rst_n;
    logic        [7:0]  paddr;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic        [31:0] pwdata;
    logic        [31:0] prdata;
    logic               pready;
    logic               pslverr;
    logic signed [17:0] code_a;     // Input code, controller side
    logic signed [17:0] code_b;     // Input code, bench side
    logic        [15:0] res_a;
    logic        [15:0] res_b;
    logic        [1:0]  conv;       // Converting flags, a then b
    logic        [1:0]  pd;
    logic        [1:0]  chain;
    logic        [1:0]  busy;
    logic        [31:0] rd;         // Last read word
    logic               err;        // Last error response
    int                 num_errors;
    int                 n_tests;
    int                 n;
    logic signed [17:0] codes [5];  // Under, over, mid, low, top
    sar_link_if link ();
    sar_link_if chain_link ();      // Bench plays controller here
    sar_adc_host sar_adc_host_i (.clk(clk), .rst_n(rst_n), .link(link), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    sar_adc_device sar_adc_device_i (.clk(clk), .rst_n(rst_n), .link(link),
        .analog_code(code_a), .last_result(res_a), .converting(conv[0]),
        .powered_down(pd[0]), .chain_mode(chain[0]), .busy_enabled(busy[0]));
    // Second converter; its link faces the bench only
    sar_adc_device sar_adc_device_chain_i (.clk(clk), .rst_n(rst_n), .link(chain_link),
        .analog_code(code_b), .last_result(res_b), .converting(conv[1]),
        .powered_down(pd[1]), .chain_mode(chain[1]), .busy_enabled(busy[1]));
    sar_link_assertions sar_link_assertions_i (.clk(clk), .rst_n(rst_n),
        .convert_start(link.convert_start), .serial_clock(link.serial_clock),
        .serial_data_in(link.serial_data_in), .sdo_out(link.sdo_out),
        .sdo_oe_n(link.sdo_oe_n), .sdo_line(link.sdo_line));
    // Free-running clock
    always #25 clk = ~clk;
    // Expected code: straight binary, clipped at both ends
    function automatic logic [15:0] sat(input logic signed [17:0] x);
        if (x < 0) return 16'h0000;
        if (x > 18'sh0ffff) return 16'hffff;
        return x[15:0];
    endfunction : sat
    // Compare with case equality so unknowns never match
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Counts, verdict, end of run
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    // One APB transfer; request held until pready is sampled
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            num_errors++;
            give_verdict();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Wait for a converting flag, counting edges, bounded
    task automatic wait_conv(input int k, input logic v, output int c);
        c = 0;
        while (conv[k] !== v && c < 3000) begin
            @(posedge clk);
            c++;
        end
        if (conv[k] !== v) begin
            num_errors++;
            give_verdict();
        end
    endtask : wait_conv
    // Main sequence
    initial begin
        codes = '{-18'sd5, 18'sh12345, 18'sh08001, 18'sh00001, 18'sh0ffff};
        clk = 1'b0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        code_a = 18'sh00000;
        code_b = 18'sh0a5c3;
        chain_link.convert_start = 1'b0;
        chain_link.serial_clock = 1'b0;
        chain_link.serial_data_in = 1'b1;
        num_errors = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, then an unmapped word refused
        for (int a = 0; a < 12; a += 4) begin
            apb(a[7:0], 1'b0, 32'h0, rd, err);
            check("reset value", rd, 32'h0);
        end
        apb(8'h0c, 1'b1, 32'hffffffff, rd, err);
        check("unmapped refused", err, 1'b1);
        check("idle powered down", pd[0], 1'b1);
        // Every select-mode variant: 3/4-wire, with and without busy
        for (int i = 0; i < 5; i++) begin
            code_a <= codes[i];
            apb(`SAR_REG_CTRL, 1'b1, {29'h0, i[1], i[0], 1'b1}, rd, err);
            wait_conv(0, 1'b1, n);
            check("awake converting", pd[0], 1'b0);
            check("select mode", chain[0], 1'b0);
            n = 0;
            do begin
                apb(`SAR_REG_STATUS, 1'b0, 32'h0, rd, err);
                n++;
            end while (rd[1] !== 1'b1 && n < 500);
            check("done", rd[1], 1'b1);
            check("busy choice", busy[0], i[1]);
            check("powered down", pd[0], 1'b1);
            check("result", res_a, sat(codes[i]));
            apb(`SAR_REG_DATA, 1'b0, 32'h0, rd, err);
            check("serial word", rd, {16'h0, sat(codes[i])});
            apb(`SAR_REG_STATUS, 1'b1, 32'h2, rd, err);
            apb(`SAR_REG_STATUS, 1'b0, 32'h0, rd, err);
            check("done cleared", rd[1], 1'b0);
        end
        // Both select lines low: pin pulled down by the converter
        chain_link.serial_data_in <= 1'b0;
        repeat (8) @(posedge clk);
        check("both low drive", chain_link.sdo_line, 1'b0);
        // Clock high, data-in low at start rise
        chain_link.serial_clock <= 1'b1;
        repeat (4) @(posedge clk);
        chain_link.convert_start <= 1'b1;
        wait_conv(1, 1'b1, n);
        check("chain mode", chain[1], 1'b1);
        check("chain busy", busy[1], 1'b1);
        // Start blip mid-conversion must not restart it
        repeat (5) @(posedge clk);
        chain_link.convert_start <= 1'b0;
        repeat (3) @(posedge clk);
        chain_link.convert_start <= 1'b1;
        wait_conv(1, 1'b0, n);
        check("conv length", n + 8 >= `SAR_CONV_MIN_CYC &&
              n + 8 <= `SAR_CONV_MAX_CYC, 1'b1);
        check("chain result", res_b, sat(code_b));
        // Data-in rising with start, as if tied together
        chain_link.convert_start <= 1'b0;
        chain_link.serial_data_in <= 1'b0;
        chain_link.serial_clock <= 1'b0;
        repeat (8) @(posedge clk);
        chain_link.convert_start <= 1'b1;
        chain_link.serial_data_in <= 1'b1;
        wait_conv(1, 1'b1, n);
        check("tied lines chain", chain[1], 1'b1);
        check("tied lines no busy", busy[1], 1'b0);
        wait_conv(1, 1'b0, n);
        give_verdict();
    end
endmodule : tb_top
